// ### hw/external_bus_controller.v
// External bus cycle phase sequencer.
// Assumes request and timing words come from logic on core_clk.
`include "bus_cycle_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module external_bus_controller (
  input wire core_clk,
  input wire reset,
  input wire cpu_clock_halving_select,
  input wire [`CS_COUNT*`TIMING_W-1:0] chip_select_timing_regs,
  input wire req_valid,
  input wire [`CS_SEL_W-1:0] req_cs,
  input wire req_write,
  input wire [23:0] req_addr,
  input wire [15:0] req_wdata,
  output wire req_ready,
  output reg [5:0] phase_q,
  output reg cycle_done_q,
  output reg [23:0] bus_addr_q,
  output reg [15:0] bus_wdata_q,
  output reg bus_addr_oe_q,
  output reg bus_data_oe_q,
  output reg cmd_strobe_q,
  output reg write_q,
  output reg [`CS_COUNT-1:0] cs_active_q
);
  wire cpu_en;
  reg [`CNT_W-1:0] count_q;
  reg [`CS_SEL_W-1:0] cs_q;
  reg [`CS_SEL_W-1:0] last_cs_q;
  reg first_q;
  reg [5:0] phase_d;
  reg [`CNT_W-1:0] count_d;
  wire [`TIMING_W-1:0] tw;
  wire [`TIMING_W-1:0] req_tw;
  wire [`CNT_W-1:0] len_ab;
  wire [`CNT_W-1:0] len_c;
  wire [`CNT_W-1:0] len_d;
  wire [`CNT_W-1:0] len_e;
  wire [`CNT_W-1:0] len_f;
  wire win_change;
  wire last_tick;

  cpu_clock_enable cpu_clock_enable_inst (
    .core_clk(core_clk),
    .reset(reset),
    .cpu_clock_halving_select(cpu_clock_halving_select),
    .cpu_clock_period(cpu_en)
  );

  // Timing word of the region being served
  assign tw = chip_select_timing_regs[cs_q*`TIMING_W +: `TIMING_W];
  assign req_tw = chip_select_timing_regs[req_cs*`TIMING_W +: `TIMING_W];
  // Window change: other region than last cycle, or first cycle
  // Limitation: region granularity only, address bits are not compared
  assign win_change = first_q | (req_cs != last_cs_q);
  // Setup length 1..2 plus 0..3 on window change
  assign len_ab = `CNT_ONE + {5'h00, req_tw[`F_AB_LSB]}
    + (win_change ? {4'h0, req_tw[`F_WIN_MSB:`F_WIN_LSB]} : `CNT_ZERO);
  assign len_c = {4'h0, tw[`F_C_MSB:`F_C_LSB]};
  assign len_d = {5'h00, tw[`F_D_LSB]};
  assign len_e = `CNT_ONE + {1'b0, tw[`F_E_MSB:`F_E_LSB]};
  assign len_f = {4'h0, tw[`F_F_MSB:`F_F_LSB]};
  assign last_tick = (count_q == `CNT_ONE);
  // Accept only at an idle CPU edge, so setup starts aligned
  // Costs one idle CPU period between cycles, but no phase overlap
  assign req_ready = (phase_q == `PH_IDLE) & cpu_en;

  // Zero-length phases are skipped in the same edge
  always @*
  begin
    phase_d = phase_q;
    count_d = count_q;
    case (phase_q)
      `PH_IDLE:
      begin
        if (req_valid)
        begin
          phase_d = `PH_AB;
          count_d = len_ab;
        end
      end
      `PH_AB:
      begin
        count_d = count_q - `CNT_ONE;
        if (last_tick)
        begin
          if (len_c != `CNT_ZERO)
          begin
            phase_d = `PH_C;
            count_d = len_c;
          end
          else if (len_d != `CNT_ZERO)
          begin
            phase_d = `PH_D;
            count_d = len_d;
          end
          else
          begin
            phase_d = `PH_E;
            count_d = len_e;
          end
        end
      end
      `PH_C:
      begin
        count_d = count_q - `CNT_ONE;
        if (last_tick)
        begin
          if (len_d != `CNT_ZERO)
          begin
            phase_d = `PH_D;
            count_d = len_d;
          end
          else
          begin
            phase_d = `PH_E;
            count_d = len_e;
          end
        end
      end
      `PH_D:
      begin
        phase_d = `PH_E;
        count_d = len_e;
      end
      `PH_E:
      begin
        count_d = count_q - `CNT_ONE;
        if (last_tick)
        begin
          if (len_f != `CNT_ZERO)
          begin
            phase_d = `PH_F;
            count_d = len_f;
          end
          else
            phase_d = `PH_IDLE;
        end
      end
      `PH_F:
      begin
        count_d = count_q - `CNT_ONE;
        if (last_tick)
          phase_d = `PH_IDLE;
      end
      default:
      begin
        phase_d = `PH_IDLE;
        count_d = `CNT_ZERO;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `CS_COUNT; g = g + 1)
    begin : g_cs
      always @(posedge core_clk)
      begin
        if (reset)
          cs_active_q[g] <= 1'b0;
        else if (cpu_en)
          cs_active_q[g] <= (phase_d != `PH_IDLE) &&
            (((phase_q == `PH_IDLE) ? req_cs : cs_q) == g);
      end
    end
  endgenerate

  // All state moves only on CPU clock edges
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      phase_q <= `PH_IDLE;
      count_q <= `CNT_ZERO;
      cs_q <= {`CS_SEL_W{1'b0}};
      last_cs_q <= {`CS_SEL_W{1'b0}};
      first_q <= 1'b1;
      cycle_done_q <= 1'b0;
      bus_addr_q <= 24'h000000;
      bus_wdata_q <= 16'h0000;
      bus_addr_oe_q <= 1'b0;
      bus_data_oe_q <= 1'b0;
      cmd_strobe_q <= 1'b0;
      write_q <= 1'b0;
    end
    else if (cpu_en)
    begin
      phase_q <= phase_d;
      count_q <= count_d;
      // Stands a whole CPU period, so half-rate watchers see it
      cycle_done_q <= (phase_q != `PH_IDLE) && (phase_d == `PH_IDLE);
      if (phase_q == `PH_IDLE && req_valid)
      begin
        cs_q <= req_cs;
        last_cs_q <= req_cs;
        first_q <= 1'b0;
        bus_addr_q <= req_addr;
        bus_wdata_q <= req_wdata;
        write_q <= req_write;
      end
      // Address held through hold phase
      bus_addr_oe_q <= (phase_d != `PH_IDLE);
      // Write data from D onward, kept through hold
      bus_data_oe_q <= write_q && ((phase_d == `PH_E) || (phase_d == `PH_F) ||
        (phase_d == `PH_D));
      cmd_strobe_q <= (phase_d == `PH_E);
    end
  end
endmodule // external_bus_controller
`default_nettype wire

// ### hw/bus_cycle_consts.vh
// Constants for the external bus cycle phase sequencer.
// Included by bus cycle design files; definitions only.
`ifndef BUS_CYCLE_CONSTS_VH
`define BUS_CYCLE_CONSTS_VH
`define CS_COUNT 4
`define CS_SEL_W 2
`define TIMING_W 16
// Field layout of one chip-select timing word
`define F_AB_LSB 0
`define F_WIN_LSB 1
`define F_WIN_MSB 2
`define F_C_LSB 3
`define F_C_MSB 4
`define F_D_LSB 5
`define F_E_LSB 6
`define F_E_MSB 10
`define F_F_LSB 11
`define F_F_MSB 12
`define CNT_W 6
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01
`define PH_IDLE 6'h01
`define PH_AB 6'h02
`define PH_C 6'h04
`define PH_D 6'h08
`define PH_E 6'h10
`define PH_F 6'h20
`endif

// ### hw/cpu_clock_enable.v
// CPU clock enable: every master clock, or every second one.
// Assumes core_clk is the master clock and the select is synchronous.
`timescale 1ns/1ns
`default_nettype none
module cpu_clock_enable (
  input wire core_clk,
  input wire reset,
  input wire cpu_clock_halving_select,
  output wire cpu_clock_period
);
  reg toggle_q;
  always @(posedge core_clk)
  begin
    if (reset)
      toggle_q <= 1'b0;
    else
      toggle_q <= ~toggle_q;
  end
  // Full rate or master divided by two
  assign cpu_clock_period = cpu_clock_halving_select ? toggle_q : 1'b1;
endmodule // cpu_clock_enable
`default_nettype wire

// ### tb/bus_cycle_checker_asserts.sv
// Phase sequencing checks.
// Bound onto the sequencer ports.
`timescale 1ns/1ns
`default_nettype none
module bus_cycle_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic cpu_clock_halving_select,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [5:0] phase_q,
  input wire logic bus_addr_oe_q,
  input wire logic bus_data_oe_q,
  input wire logic cmd_strobe_q,
  input wire logic write_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_phase_forward: assert property ($changed(phase_q) && phase_q != 6'h01 |->
    phase_q > $past(phase_q)) else $error("phase went backwards");
  a_accept_setup: assert property (req_valid && req_ready |=> phase_q == 6'h02)
    else $error("accept did not start setup");
  a_ready_idle: assert property (req_ready |-> phase_q == 6'h01)
    else $error("ready outside idle");
  a_strobe_access: assert property (cmd_strobe_q == (phase_q == 6'h10))
    else $error("strobe not in access");
  a_addr_drive: assert property (bus_addr_oe_q == (phase_q != 6'h01))
    else $error("address drive wrong");
  a_data_drive: assert property (bus_data_oe_q |-> write_q && phase_q > 6'h04)
    else $error("data drive wrong");
  a_half_rate: assert property (cpu_clock_halving_select && $changed(phase_q)
    |=> $stable(phase_q)) else $error("phase moved off enable edge");
  a_access_max: assert property ($rose(cmd_strobe_q) |-> ##[1:64] !cmd_strobe_q)
    else $error("access too long");
  cover property (req_valid && req_ready && cpu_clock_halving_select);
  cover property ($rose(bus_data_oe_q));
  cover property ($fell(cmd_strobe_q) && !cpu_clock_halving_select);
endmodule // bus_cycle_checker
bind external_bus_controller bus_cycle_checker bus_cycle_checker_inst (.core_clk, .reset,
  .cpu_clock_halving_select, .req_valid, .req_ready, .phase_q, .bus_addr_oe_q,
  .bus_data_oe_q, .cmd_strobe_q, .write_q);
`default_nettype wire

// ### tb/mem_device_model.sv
// Far-side memory: times access, keeps written data.
// Assumes registered bus outputs on core_clk.
`timescale 1ns/1ns
`default_nettype none
module mem_device_model (
  input wire logic core_clk,
  input wire logic cmd_strobe_q,
  input wire logic write_q,
  input wire logic bus_data_oe_q,
  input wire logic [15:0] bus_wdata_q,
  output logic [7:0] acc_len = 8'h00,
  output logic [15:0] last_w = 16'h0000
);
  logic [7:0] run = 8'h00;
  always @(posedge core_clk)
  begin
    if (cmd_strobe_q)
    begin
      run <= run + 8'h01;
      if (write_q && bus_data_oe_q)
        last_w <= bus_wdata_q;
    end
    else if (run != 8'h00)
    begin
      acc_len <= run;
      run <= 8'h00;
    end
  end
endmodule // mem_device_model
`default_nettype wire

// ### tb/external_bus_controller_tb.sv
// Random and corner bus cycles at both CPU rates.
// Assumes the memory model on the bus side.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
  $display("CHECK FAILED %s expected %0d seen %0d", n, e, s); end end
module external_bus_controller_tb;
  logic core_clk = 0, reset = 1, half = 0, req_valid = 0, req_write = 0;
  logic [63:0] regs = 64'h0, t;
  logic [1:0] req_cs = 2'h0;
  logic [23:0] req_addr = 24'h0;
  logic [15:0] req_wdata = 16'h0;
  logic [31:0] seed = 32'h00008300;
  wire req_ready, cycle_done_q, cmd_strobe_q, write_q, bus_data_oe_q;
  wire [15:0] bus_wdata_q, last_w;
  wire [7:0] acc_len;
  wire [23:0] bus_addr_q;
  wire [3:0] cs_active_q;
  int failures = 0, compares = 0, prev = -1;
  always #2 core_clk = ~core_clk;
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int exp_len(input logic [15:0] w, input bit chg);
    return 2 + w[0] + (chg ? w[2:1] : 0) + w[4:3] + w[5] + w[10:6] + w[12:11];
  endfunction
  external_bus_controller external_bus_controller_inst (.core_clk, .reset,
    .cpu_clock_halving_select(half), .chip_select_timing_regs(regs), .req_valid, .req_cs,
    .req_write, .req_addr, .req_wdata, .req_ready, .phase_q(), .cycle_done_q, .bus_addr_q,
    .bus_wdata_q, .bus_addr_oe_q(), .bus_data_oe_q, .cmd_strobe_q, .write_q, .cs_active_q);
  mem_device_model mem_device_model_inst (.core_clk, .cmd_strobe_q, .write_q, .bus_data_oe_q,
    .bus_wdata_q, .acc_len, .last_w);
  task automatic xfer(input int r, input int c);
    logic [31:0] v;
    logic [15:0] w;
    bit chg;
    int n;
    v = nxt();
    if (c >= 0)
      v[1:0] = c[1:0];
    chg = (prev != v[1:0]);
    prev = v[1:0];
    @(posedge core_clk);
    // Timing word after the last update of regs has landed
    w = regs[16*v[1:0]+:16];
    {req_valid, req_cs, req_write} <= {1'b1, v[1:0], v[2]};
    {req_addr, req_wdata} <= {v[31:8], v[23:8]};
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    @(negedge core_clk);
    n = 1;
    `CHK("address", v[31:8], bus_addr_q)
    `CHK("region select", 4'h1 << v[1:0], cs_active_q)
    while (cycle_done_q !== 1'b1 && n < 400)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    `CHK("region released", 4'h0, cs_active_q)
    `CHK("cycle length", exp_len(w, chg) * r + 1, n)
    `CHK("access length", (w[10:6] + 1) * r, acc_len)
    if (v[2])
      `CHK("write data", v[23:8], last_w)
    // Leave on a rising edge so the next stimulus lands there
    @(posedge core_clk);
  endtask
  task results;
    if (failures == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    for (int r = 1; r <= 2; r++)
    begin
      reset <= 1'b1;
      half <= (r == 2);
      repeat (6) @(posedge core_clk);
      reset <= 1'b0;
      prev = -1;
      for (int i = 0; i < 16; i++)
      begin
        t = {nxt(), nxt()};
        // Extremes: all-minimum and all-maximum phases
        if (i < 3)
          t[31:0] = {16'h1FFF, 16'h0000};
        regs <= t;
        xfer(r, i < 3 ? i % 2 : -1);
      end
    end
    results;
  end
  initial
  begin
    #100000;
    failures++;
    results;
  end
endmodule // external_bus_controller_tb
`default_nettype wire
